// File: stop_irq_defs.vh
/*
 * Constants of the stop, backup and interrupt control block: register
 * offsets, field positions, mode codes, vectors and timing counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef STOP_IRQ_DEFS_VH
`define STOP_IRQ_DEFS_VH

// Register byte offsets
`define OFS_CMD 12'h000
`define OFS_IRQ_EN 12'h004
`define OFS_WAKE 12'h008
`define OFS_STOP_REL 12'h00C
`define OFS_IO_CHG 12'h010
`define OFS_STATUS 12'h014

// Command register bits
`define CMD_STOP 0
`define CMD_SET_BACKUP 1
`define CMD_CLR_BACKUP 2

// Stop release enable bits for IO and key; the external edge releases stop regardless of SREL_EXT
`define SREL_IO 0
`define SREL_EXT 1
`define SREL_KEY 2

// Request / enable bit positions per source
`define SRC_IO 3'd0
`define SRC_T1 3'd1
`define SRC_EXT 3'd2
`define SRC_PDIV 3'd3
`define SRC_T2 3'd4
`define SRC_KEY 3'd5
`define SRC_FCONV 3'd6

// Interrupt vectors
`define VEC_EXT 12'h010
`define VEC_IO 12'h014
`define VEC_T1 12'h018
`define VEC_PDIV 12'h01C
`define VEC_T2 12'h020
`define VEC_KEY 12'h024
`define VEC_FCONV 12'h028

// Power modes
`define MODE_RUN 2'h0
`define MODE_HALT 2'h1
`define MODE_STOP 2'h2

// Power options
`define PWR_BAT_1V5 2'h0
`define PWR_BAT_3V 2'h1
`define PWR_EXTV 2'h2

// Reset values
`define IRQ_EN_RST 7'h00
`define WAKE_RST 7'h00
`define STOP_REL_RST 3'h0
`define IO_CHG_RST 4'h0

// Chattering filter: settle time in ns and cycles at 8 ns
`define CLK_PERIOD_NS 8
`define IO_SETTLE_NS 64
`define IO_SETTLE_CYC ((`IO_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: stop_backup_interrupt_ctrl.v
/*
 * Stop/halt power mode control, backup flag and seven-source interrupt
 * controller, with an APB register slave for command, enable, request,
 * stop release, port change and status words.
 * Assumes the CPU core gives instruction boundary and return pulses,
 * and peripherals give one-cycle event pulses synchronous to clk.
 * Assumes port and external pin inputs are already synchronous to clk
 * and that the external pin idles at the level opposite its active edge.
 * Assumes the APB master keeps each request until pready, which comes
 * in the first access cycle.
 */
`include "stop_irq_defs.vh"

module stop_backup_interrupt_ctrl #(
    parameter [1:0] POWER_OPT = `PWR_BAT_3V,
    parameter EXT_RISING = 1,
    parameter SETTLE_CYC = `IO_SETTLE_CYC
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // CPU core handshake
    input wire instr_boundary,
    input wire return_op,
    output reg irq_accept,
    output reg push_pc,
    output reg nop_insert,
    output reg [11:0] vector,
    // Event sources
    input wire [3:0] third_io_port,
    input wire ext_irq_pin,
    input wire key_detect,
    input wire timer_one_uflow,
    input wire timer_two_uflow,
    input wire prediv_ovf,
    input wire freq_converter_stop,
    // Power control outputs
    output reg [1:0] power_mode,
    output reg osc_hold,
    output reg lcd_force_low,
    output reg backup_flag,
    output reg xtal_drive_large,
    output reg use_secondary_supply
);

    localparam [1:0] RUN = `MODE_RUN;
    localparam [1:0] HALT = `MODE_HALT;
    localparam [1:0] STOP = `MODE_STOP;
    localparam BAT = (POWER_OPT != `PWR_EXTV);
    localparam [7:0] SETTLE = SETTLE_CYC[7:0];
    localparam BAT_3V = (POWER_OPT == `PWR_BAT_3V);
    localparam EXTV_OPT = (POWER_OPT == `PWR_EXTV);
    localparam EXT_IDLE = (EXT_RISING != 0);

    reg [6:0] irq_en_r;
    reg [6:0] irq_en_nxt;
    reg [6:0] wake_r;
    reg [6:0] wake_nxt;
    reg [2:0] stop_rel_r;
    reg [3:0] io_chg_r;
    reg [1:0] mode_r;
    reg [1:0] mode_nxt;
    reg [1:0] ret_mode_r;
    reg from_stop_r;
    reg in_isr_r;
    reg io_start_r;
    reg [7:0] settle_cnt_r;
    reg ext_prev_r;
    reg backup_nxt;
    reg [2:0] sel;
    reg [11:0] sel_vec;
    reg sel_any;
    // Read data select
    reg [31:0] rd_word;
    reg rd_err;

    // Bus decode
    wire wr = psel & penable & pready & pwrite;
    wire wr_irq_en = wr & (paddr == `OFS_IRQ_EN);
    wire wr_wake = wr & (paddr == `OFS_WAKE);
    wire wr_stop_rel = wr & (paddr == `OFS_STOP_REL);
    wire wr_io_chg = wr & (paddr == `OFS_IO_CHG);
    wire rd_setup = psel & ~penable;
    wire cmd_wr = wr & (paddr == `OFS_CMD);
    wire stop_cmd = cmd_wr & pwdata[`CMD_STOP];
    wire [6:0] wake_clr = wr_wake ? pwdata[6:0] : 7'h00;
    // Event, release and acceptance terms
    wire io_high = |(third_io_port & io_chg_r);
    wire ext_edge = EXT_RISING ? (ext_irq_pin & ~ext_prev_r) :
        (~ext_irq_pin & ext_prev_r);
    wire io_settled = io_high && (settle_cnt_r == SETTLE);
    wire [6:0] events;
    wire [6:0] pend = wake_r & irq_en_r;
    wire accept_ok = (mode_r != STOP) && sel_any &&
        (instr_boundary || mode_r == HALT);
    wire stop_release = (io_high & stop_rel_r[`SREL_IO]) | ext_edge |
        (key_detect & stop_rel_r[`SREL_KEY]);
    wire halt_release = (|wake_r) | io_start_r;

    assign events[`SRC_IO] = io_settled & ~io_start_r;
    assign events[`SRC_T1] = timer_one_uflow;
    assign events[`SRC_EXT] = ext_edge;
    assign events[`SRC_PDIV] = prediv_ovf;
    assign events[`SRC_T2] = timer_two_uflow;
    assign events[`SRC_KEY] = key_detect;
    assign events[`SRC_FCONV] = freq_converter_stop;

    // Fixed priority select of enabled pending request
    always @* begin
        sel = 3'd0;
        sel_vec = 12'h000;
        sel_any = 1'b1;
        if (pend[`SRC_PDIV]) begin
            sel = `SRC_PDIV;
            sel_vec = `VEC_PDIV;
        end else if (pend[`SRC_T1]) begin
            sel = `SRC_T1;
            sel_vec = `VEC_T1;
        end else if (pend[`SRC_T2]) begin
            sel = `SRC_T2;
            sel_vec = `VEC_T2;
        end else if (pend[`SRC_FCONV]) begin
            sel = `SRC_FCONV;
            sel_vec = `VEC_FCONV;
        end else if (pend[`SRC_IO]) begin
            sel = `SRC_IO;
            sel_vec = `VEC_IO;
        end else if (pend[`SRC_EXT]) begin
            sel = `SRC_EXT;
            sel_vec = `VEC_EXT;
        end else if (pend[`SRC_KEY]) begin
            sel = `SRC_KEY;
            sel_vec = `VEC_KEY;
        end else begin
            sel_any = 1'b0;
        end
    end

    // Request flags and enables
    always @* begin
        wake_nxt = wake_r & ~wake_clr;
        irq_en_nxt = irq_en_r;
        if (wr_irq_en) begin
            irq_en_nxt = pwdata[6:0];
        end
        if (accept_ok) begin
            irq_en_nxt = 7'h00;
            wake_nxt[sel] = 1'b0;
        end
        wake_nxt = wake_nxt | events;
    end

    // Power mode sequencing
    always @* begin
        mode_nxt = mode_r;
        case (mode_r)
            RUN: begin
                if (stop_cmd) begin
                    mode_nxt = (stop_release | halt_release) ? HALT : STOP;
                end
            end
            HALT: begin
                if (accept_ok || halt_release) begin
                    mode_nxt = RUN;
                end else if (from_stop_r && !io_high && !ext_edge) begin
                    mode_nxt = STOP;
                end
            end
            STOP: begin
                if (stop_release) begin
                    mode_nxt = HALT;
                end
            end
            default: mode_nxt = RUN;
        endcase
        if (mode_r == RUN && return_op && in_isr_r) begin
            mode_nxt = ret_mode_r;
        end
    end

    // Backup flag
    always @* begin
        backup_nxt = backup_flag;
        if (cmd_wr && pwdata[`CMD_SET_BACKUP]) begin
            backup_nxt = 1'b1;
        end
        if (cmd_wr && pwdata[`CMD_CLR_BACKUP]) begin
            backup_nxt = 1'b0;
        end
        if (mode_nxt == STOP) begin
            backup_nxt = 1'b1;
        end
    end

    // Bus-written control registers and request flags
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_r <= `IRQ_EN_RST;
            wake_r <= `WAKE_RST;
            stop_rel_r <= `STOP_REL_RST;
            io_chg_r <= `IO_CHG_RST;
        end else begin
            irq_en_r <= irq_en_nxt;
            wake_r <= wake_nxt;
            if (wr_stop_rel) begin
                stop_rel_r <= pwdata[2:0];
            end
            if (wr_io_chg) begin
                io_chg_r <= pwdata[3:0];
            end
        end
    end

    // Chattering filter on enabled port inputs and start flag
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_start_r <= 1'b0;
            settle_cnt_r <= 8'h00;
        end else begin
            if (!io_high) begin
                settle_cnt_r <= 8'h00;
            end else if (settle_cnt_r != SETTLE) begin
                settle_cnt_r <= settle_cnt_r + 8'h01;
            end
            if (events[`SRC_IO]) begin
                io_start_r <= 1'b1;
            end else if (wake_clr[`SRC_IO]) begin
                io_start_r <= 1'b0;
            end
        end
    end

    // External pin history; reset to the post-edge level so reset makes no false edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_prev_r <= EXT_IDLE;
        end else begin
            ext_prev_r <= ext_irq_pin;
        end
    end

    // Power mode, stop origin and service tracking
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= RUN;
            ret_mode_r <= RUN;
            from_stop_r <= 1'b0;
            in_isr_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            if (mode_r == STOP && mode_nxt == HALT) begin
                from_stop_r <= 1'b1;
            end else if (mode_nxt != HALT) begin
                from_stop_r <= 1'b0;
            end
            if (accept_ok) begin
                ret_mode_r <= from_stop_r ? STOP : RUN;
                in_isr_r <= 1'b1;
            end else if (return_op) begin
                in_isr_r <= 1'b0;
            end
        end
    end

    // Core handshake
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_accept <= 1'b0;
            push_pc <= 1'b0;
            nop_insert <= 1'b0;
            vector <= 12'h000;
        end else begin
            irq_accept <= accept_ok;
            push_pc <= accept_ok;
            nop_insert <= irq_accept;
            if (accept_ok) begin
                vector <= sel_vec;
            end
        end
    end

    // Power outputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_mode <= RUN;
            osc_hold <= 1'b0;
            lcd_force_low <= 1'b0;
            backup_flag <= BAT;
            xtal_drive_large <= 1'b1;
            use_secondary_supply <= BAT_3V | EXTV_OPT;
        end else begin
            power_mode <= mode_nxt;
            osc_hold <= (mode_nxt == STOP);
            lcd_force_low <= (mode_nxt == STOP);
            backup_flag <= backup_nxt;
            xtal_drive_large <= backup_nxt | ~BAT;
            use_secondary_supply <= EXTV_OPT | (BAT_3V & backup_nxt);
        end
    end

    // Read data select
    always @* begin
        rd_word = 32'h00000000;
        rd_err = 1'b0;
        case (paddr)
            `OFS_CMD: rd_word = 32'h00000000;
            `OFS_IRQ_EN: rd_word = {25'h0000000, irq_en_r};
            `OFS_WAKE: rd_word = {25'h0000000, wake_r};
            `OFS_STOP_REL: rd_word = {29'h00000000, stop_rel_r};
            `OFS_IO_CHG: rd_word = {28'h0000000, io_chg_r};
            `OFS_STATUS: rd_word = {26'h0000000, io_start_r,
                use_secondary_supply, xtal_drive_large,
                backup_flag, mode_r};
            default: rd_err = 1'b1;
        endcase
    end

    // APB: one wait-free access phase
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= rd_setup;
            pslverr <= rd_setup & rd_err;
            prdata <= rd_setup ? rd_word : 32'h00000000;
        end
    end

endmodule // stop_backup_interrupt_ctrl

// File: stop_backup_interrupt_ctrl_asserts.sv
/* Port checker for the stop, backup and interrupt block.
   Assumes one clock and an active-low asynchronous reset. */
module stop_irq_checker #(
    parameter [1:0] POWER_OPT = 2'h1
) (
    input wire clk,
    input wire rst_n,
    input wire irq_accept,
    input wire push_pc,
    input wire nop_insert,
    input wire [11:0] vector,
    input wire [1:0] power_mode,
    input wire osc_hold,
    input wire lcd_force_low,
    input wire backup_flag,
    input wire xtal_drive_large,
    input wire use_secondary_supply
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire stop = power_mode == 2'h2;
    wire ext_opt = POWER_OPT == 2'h2;
    wire sec_opt = POWER_OPT != 2'h0;

    a_stop_outputs_low: assert property (
        stop |-> osc_hold && lcd_force_low) else $error("stop not held");
    a_stop_sets_backup: assert property (
        stop |-> backup_flag) else $error("stop without backup");
    a_stop_exit_halt: assert property (
        stop ##1 !stop |-> power_mode == 2'h1) else $error("exit not halt");
    a_accept_push_nop: assert property (
        irq_accept |-> push_pc ##1 nop_insert) else $error("no push or nop");
    a_vector_only_accept: assert property (
        !$stable(vector) |-> irq_accept) else $error("vector moved");
    a_no_accept_stop: assert property (
        irq_accept |-> $past(power_mode) != 2'h2) else $error("taken in stop");
    a_xtal_drive_sel: assert property (
        $stable(backup_flag) |-> xtal_drive_large == (backup_flag | ext_opt))
        else $error("drive wrong");
    a_supply_sel: assert property (
        $stable(backup_flag) |->
        use_secondary_supply == (ext_opt | (sec_opt & backup_flag)))
        else $error("supply wrong");

    c_accept: cover property (irq_accept);
    c_stop_halt: cover property (stop ##1 power_mode == 2'h1);
    c_backup_off: cover property ($fell(backup_flag));
endmodule // stop_irq_checker

bind stop_backup_interrupt_ctrl stop_irq_checker #(.POWER_OPT(POWER_OPT)) chk (.*);

// File: cpu_core_model.sv
/* Core stand-in: regular instruction boundaries, return on request.
   Assumes the bench raises ret_req for one cycle. */
module cpu_core_model #(
    parameter GAP = 3
) (
    input wire clk,
    input wire rst_n,
    input wire ret_req,
    output logic instr_boundary,
    output logic return_op
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            instr_boundary <= 1'b0;
            return_op <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == 4'(GAP)) ? 4'h0 : cnt_r + 4'h1;
            instr_boundary <= cnt_r == 4'(GAP);
            return_op <= ret_req;
        end
    end
endmodule // cpu_core_model

// File: stop_backup_interrupt_ctrl_tb_top.sv
/* Self-checking bench: APB master, event stimulus, core model.
   Assumes the design header and the checker are compiled first. */
module stop_backup_interrupt_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, vector;
    logic [31:0] pwdata, prdata, rd;
    logic irq_accept, push_pc, nop_insert, instr_boundary, return_op;
    logic [3:0] third_io_port;
    logic ext_irq_pin, key_detect, timer_one_uflow, timer_two_uflow;
    logic prediv_ovf, freq_converter_stop, ret_req, err, b;
    logic [1:0] power_mode;
    logic osc_hold, lcd_force_low, backup_flag;
    logic xtal_drive_large, use_secondary_supply;
    logic [6:0] m, pend;
    logic [2:0] c;
    int fail_count, num_checks, s;
    int order[7] = '{3, 1, 4, 6, 0, 2, 5};
    logic [11:0] vt[7] = '{12'h014, 12'h018, 12'h010, 12'h01C,
                           12'h020, 12'h024, 12'h028};

    stop_backup_interrupt_ctrl #(.POWER_OPT(2'h1), .SETTLE_CYC(2)) dut (.*);
    cpu_core_model core (.*);

    function automatic int top_src(input logic [6:0] p);
        for (int i = 0; i < 7; i++)
            if (p[order[i]]) return order[i];
        return 0;
    endfunction

    function automatic logic exp_bcf(input logic [2:0] k, input logic o);
        return k[2] ? 1'b0 : (k[1] ? 1'b1 : o);
    endfunction

    task automatic conclude();
        $display("checks=%0d fails=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            fail_count++;
            conclude();
        end
    endtask

    task automatic wait_on(input bit irq, input logic [1:0] md);
        int n;
        n = 0;
        while ((irq ? irq_accept !== 1'b1 : power_mode !== md) && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) begin
            fail_count++;
            conclude();
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        {rst_n, psel, penable, pwrite, ret_req, ext_irq_pin} = 6'h00;
        {key_detect, timer_one_uflow, timer_two_uflow} = 3'h0;
        {prediv_ovf, freq_converter_stop, third_io_port} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        void'($urandom(32'h0076f9e2));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(backup_flag, 1);
        apb(0, 12'h014, 0);
        chk(rd, 32'h1C);
        apb(0, 12'h0FC, 0);
        chk(err, 1);
        b = 1'b1;
        for (int i = 0; i < 8; i++) begin
            c = 3'($urandom) & 3'h6;
            apb(1, 12'h000, {29'h0, c});
            @(posedge clk);
            b = exp_bcf(c, b);
            chk({backup_flag, xtal_drive_large, use_secondary_supply},
                {b, b, b});
        end
        apb(1, 12'h010, 32'h1);
        apb(1, 12'h008, 32'h7F);
        ext_irq_pin <= 1'b1;
        third_io_port <= 4'h1;
        {key_detect, timer_one_uflow, timer_two_uflow} <= 3'h7;
        {prediv_ovf, freq_converter_stop} <= 2'h3;
        @(posedge clk);
        {key_detect, timer_one_uflow, timer_two_uflow} <= 3'h0;
        {prediv_ovf, freq_converter_stop} <= 2'h0;
        repeat (6) @(posedge clk);
        third_io_port <= 4'h0;
        ext_irq_pin <= 1'b0;
        pend = 7'h7F;
        while (pend != 7'h0) begin
            m = 7'($urandom);
            if ((m & pend) == 7'h0) continue;
            apb(1, 12'h004, {25'h0, m});
            s = top_src(m & pend);
            wait_on(1, 2'h0);
            chk(vector, vt[s]);
            pend[s] = 1'b0;
        end
        apb(0, 12'h008, 0);
        chk(rd, 0);
        apb(1, 12'h004, 32'h04);
        apb(1, 12'h00C, 32'h1);
        apb(1, 12'h008, 32'h7F);
        apb(1, 12'h000, 32'h4);
        apb(1, 12'h000, 32'h1);
        chk({power_mode, backup_flag, osc_hold, lcd_force_low}, 5'h17);
        third_io_port <= 4'h1;
        @(posedge clk);
        third_io_port <= 4'h0;
        repeat (8) @(posedge clk);
        chk(power_mode, 2'h2);
        ext_irq_pin <= 1'b1;
        wait_on(1, 2'h0);
        chk(vector, 12'h010);
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        wait_on(0, 2'h2);
        apb(0, 12'h008, 0);
        chk(rd, 0);
        third_io_port <= 4'h1;
        wait_on(0, 2'h0);
        apb(1, 12'h000, 32'h1);
        chk(power_mode, 2'h1);
        conclude();
    end
endmodule // stop_backup_interrupt_ctrl_tb_top
